// ==== include/rly_pkg.sv ====
// Constants and types for one binary output relay channel.
// Assumes a 40 MHz clock and settings held stable by the parameter store.
// Contract
// - The selected signals are ORed and the OR result may be inverted, inversion off by default.
// - Each selected signal may be inverted before the OR, inversion off by default.
// - With all input inversions and the collective inversion on, the channel acts as an AND.
// - After any relay change the new state is held at least the hold time, 0 to 300 s, default 0; the free-running tick can cut the first 10 ms step short.
// - With latching on, a picked-up relay stays picked up after its drive goes; default on.
// - The channel's own acknowledge clears the latch and acts only while latching is on.
// - Working-current or closed-circuit principle is selectable, working-current by default.
// - A latched relay releases only on an acknowledge, even if latching is later turned off.
// - The hold time applies to both pick-up and release.
package rly_pkg;
	localparam int NUM_IN = 7;
	localparam int CLK_HZ = 40_000_000;
	// Times count in 10 ms steps; a coarse tick keeps the timers at 15 bits
	localparam int TICK_MS = 10;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int TIME_MAX_CS = 30000;
	localparam int TIME_W = 15;
	localparam int PRE_W = 19;
	localparam logic [TIME_W-1:0] TIME_DEF = 15'h0000;
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);

	typedef enum logic {
		RLY_WORKING,
		RLY_CLOSED
	} rly_mode_e;

	typedef struct packed {
		logic [NUM_IN-1:0] sel;
		logic [NUM_IN-1:0] inv;
		logic inv_all;
		logic latch_en;
		rly_mode_e mode;
		logic [TIME_W-1:0] t_hold;
		logic [TIME_W-1:0] t_off;
	} rly_cfg_s;

	localparam rly_cfg_s CFG_DEF = '{
		sel: 7'h01, inv: 7'h00, inv_all: 1'b0, latch_en: 1'b1,
		mode: RLY_WORKING, t_hold: TIME_DEF, t_off: TIME_DEF
	};
endpackage

// ==== core/rly_channel.sv ====
// One relay output channel: signal combination, off delay, latch, hold time, principle.
// Assumes sig_in and ack come from logic on clk; times in 10 ms units, capped at 300 s.
`timescale 1ns/10ps
module rly_channel (
	input wire logic clk,
	input wire logic rst,
	input wire rly_pkg::rly_cfg_s cfg,
	input wire logic [rly_pkg::NUM_IN-1:0] sig_in,
	input wire logic ack,
	output logic coil_reg,
	output logic state_reg,
	output logic latched_reg
);
	typedef enum {ST_REL, ST_PICK} rly_st_e;

	function automatic logic [rly_pkg::TIME_W-1:0] clamp_t(input logic [rly_pkg::TIME_W-1:0] t);
		clamp_t = (t > rly_pkg::TIME_W'(rly_pkg::TIME_MAX_CS))
			? rly_pkg::TIME_W'(rly_pkg::TIME_MAX_CS) : t;
	endfunction

	// Shared by hold and off timers; stops at zero so an idle timer never wraps
	function automatic logic [rly_pkg::TIME_W-1:0] dec_t(input logic [rly_pkg::TIME_W-1:0] t,
		input logic step);
		dec_t = (step && (t != '0)) ? (t - 1'b1) : t;
	endfunction

	// Loop form of the combination, kept apart from the gate form it checks
	function automatic logic or_ref(input logic [rly_pkg::NUM_IN-1:0] s,
		input logic [rly_pkg::NUM_IN-1:0] iv, input logic [rly_pkg::NUM_IN-1:0] sl);
		or_ref = 1'b0;
		for (int i = 0; i < rly_pkg::NUM_IN; i++) begin
			if (sl[i] && (s[i] != iv[i])) or_ref = 1'b1;
		end
	endfunction

	rly_st_e st_reg, st_next;
	logic [rly_pkg::PRE_W-1:0] pre_reg;
	logic [rly_pkg::TIME_W-1:0] hold_reg, hold_next;
	logic [rly_pkg::TIME_W-1:0] off_reg, off_next;
	logic latched_next;

	wire logic [rly_pkg::NUM_IN-1:0] eff_in = (sig_in ^ cfg.inv) & cfg.sel;
	wire logic comb = (|eff_in) ^ cfg.inv_all;
	wire logic tick = (pre_reg == rly_pkg::PRE_LAST);
	wire logic hold_busy = (hold_reg != '0);
	// Off delay runs while combined signal is low; high reloads it
	wire logic drive = comb || (off_reg != '0);
	// Ack is ignored unless latching is on; an existing latch still needs it
	wire logic ack_eff = ack && cfg.latch_en;
	wire logic want = drive || (latched_reg && !ack_eff);
	wire logic change = !hold_busy && (want != (st_reg == ST_PICK));

	always_ff @(posedge clk) begin
		if (rst || tick) pre_reg <= '0;
		else pre_reg <= pre_reg + 1'b1;
	end

	always_comb begin
		off_next = off_reg;
		if (comb) off_next = clamp_t(cfg.t_off);
		else off_next = dec_t(off_reg, tick);
		st_next = st_reg;
		// A change is only taken once the hold timer is idle
		case (st_reg)
			ST_REL: if (change) st_next = ST_PICK;
			ST_PICK: if (change) st_next = ST_REL;
			default: st_next = ST_REL;
		endcase
		hold_next = hold_reg;
		if (change) hold_next = clamp_t(cfg.t_hold);
		else hold_next = dec_t(hold_reg, tick);
		latched_next = latched_reg;
		if (ack_eff) latched_next = 1'b0;
		if (st_next == ST_PICK && cfg.latch_en) latched_next = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= ST_REL;
			hold_reg <= '0;
			off_reg <= '0;
			latched_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			hold_reg <= hold_next;
			off_reg <= off_next;
			latched_reg <= latched_next;
		end
	end

	// Closed-circuit energises the coil while released, so a broken wire reads as pickup
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= 1'b0;
			coil_reg <= 1'b0;
		end else begin
			state_reg <= (st_next == ST_PICK);
			coil_reg <= (st_next == ST_PICK) ^ (cfg.mode == rly_pkg::RLY_CLOSED);
		end
	end

	property p_hold;
		@(posedge clk) disable iff (rst)
		(st_reg != $past(st_reg)) |-> (hold_reg == clamp_t(cfg.t_hold));
	endproperty
	a_hold: assert property (p_hold) else $error("hold not loaded on change");

	property p_hold_block;
		@(posedge clk) disable iff (rst)
		hold_busy |=> (st_reg == $past(st_reg));
	endproperty
	a_hold_block: assert property (p_hold_block) else $error("state changed in hold");

	property p_or;
		@(posedge clk) disable iff (rst)
		(!hold_busy && comb && st_reg == ST_REL) |=> (st_reg == ST_PICK);
	endproperty
	a_or: assert property (p_or) else $error("combined signal did not pick up");

	property p_inv;
		@(posedge clk) disable iff (rst)
		(cfg.sel != '0) |-> (comb == (or_ref(sig_in, cfg.inv, cfg.sel) != cfg.inv_all));
	endproperty
	a_inv: assert property (p_inv) else $error("inversion wrong");

	property p_and;
		@(posedge clk) disable iff (rst)
		(cfg.inv_all && ((cfg.inv & cfg.sel) == cfg.sel))
			|-> (comb == ((sig_in & cfg.sel) == cfg.sel));
	endproperty
	a_and: assert property (p_and) else $error("and form wrong");

	property p_latch;
		@(posedge clk) disable iff (rst)
		(latched_reg && !ack_eff) |=> (latched_reg && st_reg == ST_PICK);
	endproperty
	a_latch: assert property (p_latch) else $error("latch dropped without ack");

	property p_ack_gate;
		@(posedge clk) disable iff (rst)
		(latched_reg && !cfg.latch_en) |=> latched_reg;
	endproperty
	a_ack_gate: assert property (p_ack_gate) else $error("ack acted with latch off");

	property p_mode;
		@(posedge clk) disable iff (rst)
		1'b1 |=> (coil_reg == (state_reg ^ ($past(cfg.mode) == rly_pkg::RLY_CLOSED)));
	endproperty
	a_mode: assert property (p_mode) else $error("coil principle wrong");

	property p_off;
		@(posedge clk) disable iff (rst)
		(comb && cfg.t_off != '0) |=> (off_reg != '0);
	endproperty
	a_off: assert property (p_off) else $error("off delay not armed");

	property p_rel;
		@(posedge clk) disable iff (rst)
		(st_reg == ST_PICK && !hold_busy && !want) |=> (st_reg == ST_REL);
	endproperty
	a_rel: assert property (p_rel) else $error("release not taken after hold");

	property p_off_keep;
		@(posedge clk) disable iff (rst)
		(!comb && off_reg != '0 && st_reg == ST_PICK) |=> (st_reg == ST_PICK);
	endproperty
	a_off_keep: assert property (p_off_keep) else $error("released inside off delay");

	property p_off_count;
		@(posedge clk) disable iff (rst)
		!comb |=> (off_reg <= $past(off_reg));
	endproperty
	a_off_count: assert property (p_off_count) else $error("off delay grew while low");

	// Hold may only be reloaded by a change, never stretched in between
	property p_hold_count;
		@(posedge clk) disable iff (rst)
		!change |=> (hold_reg <= $past(hold_reg));
	endproperty
	a_hold_count: assert property (p_hold_count) else $error("hold grew without change");

	property p_tick_step;
		@(posedge clk) disable iff (rst)
		(hold_busy && !tick) |=> (hold_reg == $past(hold_reg));
	endproperty
	a_tick_step: assert property (p_tick_step) else $error("hold moved off tick");

	property p_latch_set;
		@(posedge clk) disable iff (rst)
		(cfg.latch_en && comb && !hold_busy && st_reg == ST_REL) |=> latched_reg;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("pickup did not latch");

	property p_no_latch;
		@(posedge clk) disable iff (rst)
		(!cfg.latch_en && !latched_reg) |=> !latched_reg;
	endproperty
	a_no_latch: assert property (p_no_latch) else $error("latched with latching off");

	// Ack with nothing driving must drop both the latch and the relay
	property p_ack_clear;
		@(posedge clk) disable iff (rst)
		(latched_reg && ack_eff && !hold_busy && !drive) |=> (!latched_reg && st_reg == ST_REL);
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear latch");

	property p_range;
		@(posedge clk) disable iff (rst)
		(hold_reg <= rly_pkg::TIME_W'(rly_pkg::TIME_MAX_CS))
			&& (off_reg <= rly_pkg::TIME_W'(rly_pkg::TIME_MAX_CS));
	endproperty
	a_range: assert property (p_range) else $error("timer above range");

	// The prescaler must wrap at the tick count or every time base stretches
	property p_pre;
		@(posedge clk) disable iff (rst)
		pre_reg <= rly_pkg::PRE_LAST;
	endproperty
	a_pre: assert property (p_pre) else $error("prescaler overran");

	// Only the working principle is checked here; closed-circuit is covered by a_mode
	property p_work_rest;
		@(posedge clk) disable iff (rst)
		($stable(cfg.mode) && cfg.mode == rly_pkg::RLY_WORKING && !state_reg) |-> !coil_reg;
	endproperty
	a_work_rest: assert property (p_work_rest) else $error("coil on while released");
endmodule // rly_channel

// ==== tb/rly_channel_tb.sv ====
// Self-checking bench for one relay output channel, driving its ports directly.
// Assumes hold and off-delay ticks never arrive early in a short run after reset.
`timescale 1ns/10ps
module rly_channel_tb;
	logic clk;
	logic rst;
	rly_pkg::rly_cfg_s cfg;
	logic [rly_pkg::NUM_IN-1:0] sig_in;
	logic ack;
	logic coil_reg;
	logic state_reg;
	logic latched_reg;
	int miscompares;
	int checks_done;
	logic [6:0] sels [4] = '{7'h7f, 7'h05, 7'h7f, 7'h7f};
	logic [6:0] invs [4] = '{7'h00, 7'h00, 7'h7f, 7'h7f};
	logic [6:0] sigs [5] = '{7'h00, 7'h01, 7'h04, 7'h7f, 7'h40};
	logic c;
	rly_channel rly_channel_inst(.clk(clk), .rst(rst), .cfg(cfg), .sig_in(sig_in), .ack(ack),
		.coil_reg(coil_reg), .state_reg(state_reg), .latched_reg(latched_reg));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task conclude;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task do_reset;
		@(negedge clk);
		rst = 1'b1;
		sig_in = 7'h00;
		ack = 1'b0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
	endtask
	// Inputs change on a falling edge; outputs are read n falling edges later
	task step(input logic [6:0] s, input logic a, input int n);
		sig_in = s;
		ack = a;
		repeat (n) @(negedge clk);
	endtask
	task expect_out(input logic [2:0] exp);
		checks_done++;
		if ({state_reg, coil_reg, latched_reg} !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got %h exp %h", $time, {state_reg, coil_reg, latched_reg}, exp);
		end
	endtask
	initial begin
		miscompares = 0;
		checks_done = 0;
		rst = 1'b1;
		sig_in = 7'h00;
		ack = 1'b0;
		cfg = rly_pkg::CFG_DEF;
		cfg.latch_en = 1'b0;
		do_reset();
		expect_out(3'h0);
		// Odd configs run closed-circuit, so the coil is the inverse of the state
		for (int k = 0; k < 4; k++) begin
			cfg.sel = sels[k];
			cfg.inv = invs[k];
			cfg.inv_all = k[1] & k[0];
			cfg.mode = k[0] ? rly_pkg::RLY_CLOSED : rly_pkg::RLY_WORKING;
			for (int j = 0; j < 5; j++) begin
				c = (k == 3) ? (sigs[j] == 7'h7f) : (|((sigs[j] ^ invs[k]) & sels[k]));
				step(sigs[j], 1'b0, 2);
				expect_out({c, c ^ k[0], 1'b0});
			end
		end
		cfg = rly_pkg::CFG_DEF;
		step(7'h00, 1'b0, 2);
		step(7'h01, 1'b0, 2);
		expect_out(3'h7);
		step(7'h00, 1'b0, 3);
		expect_out(3'h7);
		cfg.latch_en = 1'b0;
		step(7'h00, 1'b1, 3);
		expect_out(3'h7);
		cfg.latch_en = 1'b1;
		step(7'h00, 1'b1, 2);
		expect_out(3'h0);
		cfg.latch_en = 1'b0;
		cfg.t_off = 15'h0002;
		step(7'h01, 1'b0, 2);
		step(7'h00, 1'b0, 200);
		expect_out(3'h6);
		do_reset();
		expect_out(3'h0);
		cfg.t_off = 15'h0000;
		cfg.t_hold = 15'h0002;
		step(7'h01, 1'b0, 2);
		expect_out(3'h6);
		step(7'h00, 1'b0, 200);
		expect_out(3'h6);
		conclude();
	end
	initial begin
		#(2000 * 25);
		miscompares++;
		conclude();
	end
endmodule // rly_channel_tb
